/* File: logic/jlc_cfg.svh */
`ifndef JLC_CFG_SVH
`define JLC_CFG_SVH

// register offsets
`define JLC_OFS_EN 12'h200
`define JLC_OFS_MODE 12'h201
`define JLC_OFS_KM1 12'h202
`define JLC_OFS_SYNC 12'h203
`define JLC_OFS_CTRL 12'h204
`define JLC_OFS_STAT 12'h20F

// reset values
`define JLC_RST_EN 1'h1
`define JLC_RST_MODE 6'h00
`define JLC_RST_KM1 8'h1F
`define JLC_RST_SYNC 1'h1
`define JLC_RST_CTRL 5'h03
`define JLC_RST_K 12'h020

// link control field positions
`define JLC_B_ULM 4
`define JLC_B_SSH 3
`define JLC_B_SSL 2
`define JLC_B_FMT 1
`define JLC_B_SCR 0
`define JLC_CTRL_W 5
`define JLC_MODE_W 6

// sync source codes
`define JLC_SRC_SE 2'h0
`define JLC_SRC_TS 2'h1
`define JLC_SRC_NONE 2'h2

// 64b/66b multiframe numerator and lane mapping
`define JLC_K64_NUM 8'h00
`define JLC_LANE_UPPER 4'h4
`define JLC_MAX_UPPER_L 4'h4
`define JLC_LANES 8

`endif

/* File: logic/jlc_pkg.sv */
package jlc_pkg;
  typedef logic [11:0] jlc_addr_t;
  typedef logic [7:0] jlc_byte_t;
  typedef logic [11:0] jlc_kval_t;
  typedef logic [1:0] jlc_src_t;
endpackage

/* File: logic/jlc_link_regs.sv */
`include "jlc_cfg.svh"

module jlc_link_regs (
  input wire logic sys_clk,
  input wire logic nrst,
  input jlc_pkg::jlc_addr_t reg_addr,
  input jlc_pkg::jlc_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output jlc_pkg::jlc_byte_t reg_rdata,
  input wire logic mode_is_64b66b,
  input wire logic [3:0] mode_e,
  input wire logic [7:0] mode_f,
  input wire logic [3:0] mode_lanes,
  input wire logic frame_tick,
  input wire logic sysref_pin,
  input wire logic sync_se_n_pin,
  input wire logic sync_ts_n_pin,
  output logic link_rst_n,
  output logic serdes_pd,
  output logic link_clk_en,
  output logic [5:0] link_output_mode,
  output jlc_pkg::jlc_kval_t frames_per_multiframe,
  output jlc_pkg::jlc_kval_t mfc_value,
  output logic mfc_boundary,
  output logic sync_request,
  output logic sample_twos_comp,
  output logic scrambler_active,
  output logic [`JLC_LANES-1:0] lane_en
);

  logic en_q;
  logic [`JLC_MODE_W-1:0] mode_q;
  jlc_pkg::jlc_byte_t km1_q;
  logic ssync_n_q;
  logic [`JLC_CTRL_W-1:0] ctrl_q;
  jlc_pkg::jlc_src_t src;
  logic [1:0] se_sy_q;
  logic [1:0] ts_sy_q;
  logic [2:0] sr_sy_q;
  logic sysref_rise;
  jlc_pkg::jlc_kval_t k_d;
  jlc_pkg::jlc_kval_t k64;
  jlc_pkg::jlc_kval_t num;
  jlc_pkg::jlc_kval_t den;
  logic sync_d;
  logic [3:0] base;

  assign src = ctrl_q[`JLC_B_SSH:`JLC_B_SSL];

  // register writes
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      en_q <= `JLC_RST_EN;
      mode_q <= `JLC_RST_MODE;
      km1_q <= `JLC_RST_KM1;
      ssync_n_q <= `JLC_RST_SYNC;
      ctrl_q <= `JLC_RST_CTRL;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `JLC_OFS_EN: en_q <= reg_wdata[0];
        `JLC_OFS_MODE: mode_q <= reg_wdata[`JLC_MODE_W-1:0];
        `JLC_OFS_KM1: km1_q <= reg_wdata;
        `JLC_OFS_SYNC: ssync_n_q <= reg_wdata[0];
        `JLC_OFS_CTRL: ctrl_q <= reg_wdata[`JLC_CTRL_W-1:0];
        default: ;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe; reserved bits read zero
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `JLC_OFS_EN: reg_rdata <= {7'h00, en_q};
        `JLC_OFS_MODE: reg_rdata <= {2'h0, mode_q};
        `JLC_OFS_KM1: reg_rdata <= km1_q;
        `JLC_OFS_SYNC: reg_rdata <= {7'h00, ssync_n_q};
        `JLC_OFS_CTRL: reg_rdata <= {3'h0, ctrl_q};
        `JLC_OFS_STAT: reg_rdata <= {5'h00, mfc_boundary, link_clk_en, sync_request};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // pin synchronisers; only the second stage of each sync pin feeds logic, the sysref edge uses the second and third stages
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      se_sy_q <= 2'h3;
      ts_sy_q <= 2'h3;
      sr_sy_q <= 3'h0;
    end else begin
      se_sy_q <= {se_sy_q[0], sync_se_n_pin};
      ts_sy_q <= {ts_sy_q[0], sync_ts_n_pin};
      sr_sy_q <= {sr_sy_q[1:0], sysref_pin};
    end
  end

  assign sysref_rise = sr_sy_q[1] & ~sr_sy_q[2];

  // software request always counts; pin only when selected, code 3 acts as none
  always_comb begin
    sync_d = ~ssync_n_q;
    unique case (src)
      `JLC_SRC_SE: sync_d = sync_d | ~se_sy_q[1];
      `JLC_SRC_TS: sync_d = sync_d | ~ts_sy_q[1];
      default: sync_d = sync_d;
    endcase
  end

  // effective K; zero F from the decoder is treated as one to avoid a divide by zero
  assign num = {mode_e, `JLC_K64_NUM};
  assign den = (mode_f == 8'h00) ? 12'h001 : {4'h0, mode_f};
  assign k64 = num / den;
  assign k_d = mode_is_64b66b ? k64 : ({4'h0, km1_q} + 12'h001);

  // lane base moves up only when the mode fits in four lanes
  assign base = (ctrl_q[`JLC_B_ULM] && mode_lanes <= `JLC_MAX_UPPER_L) ?
                `JLC_LANE_UPPER : 4'h0;

  // link-side controls, registered one cycle after the fields
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      link_rst_n <= 1'b0;
      serdes_pd <= 1'b1;
      link_clk_en <= 1'b0;
      link_output_mode <= `JLC_RST_MODE;
      frames_per_multiframe <= `JLC_RST_K;
      sync_request <= 1'b0;
      sample_twos_comp <= 1'b1;
      scrambler_active <= 1'b1;
    end else begin
      link_rst_n <= en_q;
      serdes_pd <= ~en_q;
      link_clk_en <= en_q;
      link_output_mode <= mode_q;
      frames_per_multiframe <= k_d;
      sync_request <= sync_d;
      sample_twos_comp <= ctrl_q[`JLC_B_FMT];
      scrambler_active <= ctrl_q[`JLC_B_SCR] | mode_is_64b66b;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `JLC_LANES; gi++) begin : g_lane
      always_ff @(posedge sys_clk) begin
        if (!nrst) begin
          lane_en[gi] <= 1'b0;
        end else begin
          lane_en[gi] <= en_q && (4'(gi) >= base) &&
                         (4'(gi) < base + mode_lanes);
        end
      end
    end
  endgenerate

  // multiframe counter: held at zero while disabled so sysref cannot align it
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      mfc_value <= '0;
      mfc_boundary <= 1'b0;
    end else if (!en_q) begin
      mfc_value <= '0;
      mfc_boundary <= 1'b0;
    end else if (sysref_rise) begin
      mfc_value <= '0;
      mfc_boundary <= 1'b1;
    end else if (frame_tick) begin
      if (mfc_value + 12'h001 >= frames_per_multiframe) begin
        mfc_value <= '0;
        mfc_boundary <= 1'b1;
      end else begin
        mfc_value <= mfc_value + 12'h001;
        mfc_boundary <= 1'b0;
      end
    end else begin
      mfc_boundary <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_dis_wr;
    reg_wr && reg_addr == `JLC_OFS_EN && !reg_wdata[0];
  endsequence

  sequence s_en_wr;
    reg_wr && reg_addr == `JLC_OFS_EN && reg_wdata[0];
  endsequence

  disable_effect_a: assert property (s_dis_wr |-> ##2 (!link_rst_n && serdes_pd && !link_clk_en))
    else $error("link not shut down after disable");
  enable_effect_a: assert property (s_en_wr ##1 !reg_wr[*1] |-> ##1 (link_rst_n && !serdes_pd))
    else $error("link not enabled after enable write");
  mfc_hold_a: assert property (!en_q |=> mfc_value == 12'h000)
    else $error("multiframe counter moved while disabled");
  mode_write_a: assert property (reg_wr && reg_addr == `JLC_OFS_MODE |-> ##2
      link_output_mode == $past(reg_wdata[5:0], 2))
    else $error("output mode not taken from write");
  k_plain_a: assert property (!mode_is_64b66b && $stable(km1_q) |=>
      frames_per_multiframe == {4'h0, $past(km1_q)} + 12'h001)
    else $error("K not km1 plus one");
  k_wide_a: assert property (mode_is_64b66b && mode_f == 8'h01 && mode_e == 4'h1 |=>
      frames_per_multiframe == 12'h100)
    else $error("64b66b K wrong");
  soft_sync_a: assert property (reg_wr && reg_addr == `JLC_OFS_SYNC && !reg_wdata[0] |-> ##2
      sync_request)
    else $error("software sync not requested");
  none_src_a: assert property (src == `JLC_SRC_NONE && ssync_n_q |=> !sync_request)
    else $error("pin sync leaks with no source");
  ctrl_read_a: assert property (reg_rd && reg_addr == `JLC_OFS_CTRL |=>
      reg_rdata == {3'h0, $past(ctrl_q)})
    else $error("link control readback wrong");
  scr_mode_a: assert property (mode_is_64b66b |=> scrambler_active)
    else $error("64b66b mode not scrambled");
  fmt_track_a: assert property ($stable(ctrl_q) |=>
      sample_twos_comp == $past(ctrl_q[`JLC_B_FMT]))
    else $error("sample format mismatch");
  upper_lane_a: assert property (en_q && ctrl_q[`JLC_B_ULM] && mode_lanes == 4'h2 |=>
      lane_en == 8'h30)
    else $error("upper lane mapping wrong");

  // multiframe counter steps, checked as named steps
  sequence s_frame_end;
    en_q && !sysref_rise && frame_tick && (mfc_value + 12'h001 >= frames_per_multiframe);
  endsequence

  sequence s_wrapped;
    mfc_boundary && mfc_value == 12'h000;
  endsequence

  sequence s_aligned;
    en_q && sysref_rise;
  endsequence

  wrap_pulse_a: assert property (s_frame_end |=> s_wrapped)
    else $error("multiframe wrap missing");

  sysref_align_a: assert property (s_aligned |=> s_wrapped)
    else $error("sysref did not align counter");

  // the point of holding the counter: a sysref while off must leave no mark
  sysref_off_a: assert property (!en_q && sysref_rise |=> !mfc_boundary)
    else $error("sysref aligned a disabled counter");

  lane_off_a: assert property (!en_q |=> lane_en == 8'h00)
    else $error("lanes active while disabled");

  pd_pair_a: assert property (serdes_pd == !link_clk_en)
    else $error("power-down and clock gate disagree");

  // read data must fall back to zero so a stale value is never taken twice
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data stands too long");

  se_pin_a: assert property (src == `JLC_SRC_SE && !se_sy_q[1] |=> sync_request)
    else $error("single-ended sync pin ignored");

  ts_pin_a: assert property (src == `JLC_SRC_TS && !ts_sy_q[1] |=> sync_request)
    else $error("timestamp pair sync ignored");

  // a pin that is not selected must not raise a request on its own
  se_quiet_a: assert property (src != `JLC_SRC_SE && ssync_n_q && ts_sy_q[1] |=>
      !sync_request)
    else $error("unselected pin raised sync");

endmodule

/* File: verification/jlc_rx_model.sv */
// far-side receiver: frame ticks and a sync pin it can hold low
module jlc_rx_model (
  input wire logic sys_clk,
  input wire logic hold_sync,
  output logic sync_se_n_pin = 1'b1,
  output logic sync_ts_n_pin,
  output logic frame_tick = 1'b0,
  output logic sysref_pin = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_q = 2'h0;
  // timestamp pair idles high; sysref pulses only while sync is held
  assign sync_ts_n_pin = 1'b1;
  always_ff @(posedge sys_clk) begin
    sysref_pin <= hold_sync && (cnt_q == 2'h1);
    cnt_q <= cnt_q + 2'h1;
    frame_tick <= (cnt_q == 2'h3);
    sync_se_n_pin <= !hold_sync;
  end
endmodule

/* File: verification/tb_top.sv */
`include "jlc_cfg.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, is64 = 1'b0;
  logic hold_sync = 1'b0, se_n, ts_n, tick, sysref;
  jlc_pkg::jlc_addr_t reg_addr = 12'h000;
  jlc_pkg::jlc_byte_t reg_wdata = 8'h00, reg_rdata, rdv;
  logic [3:0] mode_e = 4'h2, mode_lanes = 4'h2;
  logic [7:0] mode_f = 8'h04, lane_en;
  logic rst_n, pd, clk_en, bnd, sreq, twos, scrambler_enable;
  logic [5:0] omode;
  jlc_pkg::jlc_kval_t kval, mfc;
  int n_errors = 0, tests_run = 0, nb = 0;

  jlc_rx_model jlc_rx_model_inst (.sys_clk(sys_clk), .hold_sync(hold_sync),
    .sync_se_n_pin(se_n), .sync_ts_n_pin(ts_n), .frame_tick(tick), .sysref_pin(sysref));
  jlc_link_regs jlc_link_regs_inst (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mode_is_64b66b(is64), .mode_e(mode_e), .mode_f(mode_f), .mode_lanes(mode_lanes),
    .frame_tick(tick), .sysref_pin(sysref), .sync_se_n_pin(se_n), .sync_ts_n_pin(ts_n),
    .link_rst_n(rst_n), .serdes_pd(pd), .link_clk_en(clk_en), .link_output_mode(omode),
    .frames_per_multiframe(kval), .mfc_value(mfc), .mfc_boundary(bnd),
    .sync_request(sreq), .sample_twos_comp(twos), .scrambler_active(scrambler_enable),
    .lane_en(lane_en));

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic wrap_up;
    if (n_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    rdv = reg_rdata;
    chk("reg_rdata", {4'h0, exp}, {4'h0, rdv});
  endtask

  // link is dropped around the one configuration write that each call of this task makes
  task automatic cfg(input logic [11:0] a, input logic [7:0] d);
    wr(`JLC_OFS_EN, 8'h00);
    wr(a, d);
    wr(`JLC_OFS_EN, 8'h01);
    settle(6);
  endtask

  initial begin
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    settle(2);
    rchk(`JLC_OFS_EN, 8'h01);
    rchk(`JLC_OFS_MODE, 8'h00);
    rchk(`JLC_OFS_KM1, 8'h1F);
    rchk(`JLC_OFS_SYNC, 8'h01);
    rchk(`JLC_OFS_CTRL, 8'h03);
    rchk(12'h205, 8'h00);
    chk("link_rst_n", 12'h001, {11'h0, rst_n});
    chk("k", 12'h020, kval);
    chk("lane_en", 12'h003, {4'h0, lane_en});
    chk("twos", 12'h001, {11'h0, twos});
    chk("scr", 12'h001, {11'h0, scrambler_enable});
    wr(`JLC_OFS_EN, 8'h00);
    settle(8);
    chk("link_rst_n", 12'h000, {11'h0, rst_n});
    chk("serdes_pd", 12'h001, {11'h0, pd});
    chk("clk_en", 12'h000, {11'h0, clk_en});
    chk("mfc", 12'h000, mfc);
    wr(`JLC_OFS_MODE, 8'h3F);
    rchk(`JLC_OFS_MODE, 8'h3F);
    wr(`JLC_OFS_KM1, 8'h0F);
    cfg(`JLC_OFS_CTRL, 8'h10);
    chk("mode", 12'h03F, {6'h0, omode});
    chk("k", 12'h010, kval);
    chk("lane_en", 12'h030, {4'h0, lane_en});
    chk("twos", 12'h000, {11'h0, twos});
    chk("scr", 12'h000, {11'h0, scrambler_enable});
    repeat (128) begin
      @(posedge sys_clk);
      #1;
      if (bnd) nb++;
    end
    chk("mfc_boundary", 12'h002, 12'(nb));
    @(posedge sys_clk);
    is64 <= 1'b1;
    hold_sync <= 1'b1;
    settle(6);
    chk("k", 12'h080, kval);
    chk("scr", 12'h001, {11'h0, scrambler_enable});
    chk("sync", 12'h001, {11'h0, sreq});
    cfg(`JLC_OFS_CTRL, 8'h08);
    chk("sync", 12'h000, {11'h0, sreq});
    wr(`JLC_OFS_SYNC, 8'h00);
    settle(3);
    chk("sync", 12'h001, {11'h0, sreq});
    wr(`JLC_OFS_SYNC, 8'h01);
    cfg(`JLC_OFS_CTRL, 8'h04);
    chk("sync", 12'h000, {11'h0, sreq});
    wrap_up();
  end

  initial begin
    #20000;
    n_errors++;
    wrap_up();
  end
endmodule
